// >>> rtl/io_map_pkg.sv
// constants for the i/o register bank: addresses, field positions, reset values
package io_map_pkg;

   // ****************************************
   // i/o addresses
   // ****************************************
   localparam logic [5:0] converter_control_b_addr = 6'h03;
   localparam logic [5:0] conversion_result_low_addr = 6'h04;
   localparam logic [5:0] conversion_result_high_addr = 6'h05;
   localparam logic [5:0] converter_control_a_addr = 6'h06;
   localparam logic [5:0] converter_input_select_addr = 6'h07;
   localparam logic [5:0] comparator_control_status_addr = 6'h08;
   localparam logic [5:0] serial_iface_status_addr = 6'h0e;
   localparam logic [5:0] serial_iface_control_addr = 6'h0d;
   localparam logic [5:0] general_scratch_byte_1_addr = 6'h12;
   localparam logic [5:0] pin_change_mask_addr = 6'h15;
   localparam logic [5:0] port_pin_inputs_addr = 6'h16;
   localparam logic [5:0] port_direction_addr = 6'h17;
   localparam logic [5:0] port_output_value_addr = 6'h18;
   localparam logic [5:0] clock_prescale_addr = 6'h26;
   localparam logic [5:0] pll_control_status_addr = 6'h27;
   localparam logic [5:0] timer0_compare_b_addr = 6'h28;
   localparam logic [5:0] timer0_compare_a_addr = 6'h29;
   localparam logic [5:0] timer0_control_a_addr = 6'h2a;
   localparam logic [5:0] timer1_compare_b_addr = 6'h2b;
   localparam logic [5:0] general_timer_control_addr = 6'h2c;
   localparam logic [5:0] timer1_compare_c_addr = 6'h2d;
   localparam logic [5:0] stack_pointer_low_addr = 6'h3d;
   localparam logic [5:0] stack_pointer_high_addr = 6'h3e;
   localparam logic [5:0] processor_flags_addr = 6'h3f;
   // last address reachable by single-bit instructions
   localparam logic [5:0] bit_access_top_addr = 6'h1f;

   // ****************************************
   // writable bit masks (reserved bits stay zero)
   // ****************************************
   localparam logic [7:0] port_bits_mask = 8'h3f;
   localparam logic [7:0] stack_high_mask = 8'h01;
   localparam logic [7:0] timer0_control_mask = 8'hf3;
   localparam logic [7:0] pll_write_mask = 8'h86;
   localparam logic [7:0] prescale_write_mask = 8'h8f;
   localparam logic [7:0] comparator_write_mask = 8'hcb;
   localparam logic [7:0] converter_b_mask = 8'he7;
   localparam logic [7:0] converter_a_write_mask = 8'hef;
   localparam logic [7:0] serial_status_cnt_mask = 8'h0f;

   // ****************************************
   // field positions of event flags and live bits
   // ****************************************
   localparam int pll_locked_bit = 0;
   localparam int comparator_output_bit = 5;
   localparam int comparator_irq_flag_bit = 4;
   localparam int converter_irq_flag_bit = 4;
   localparam int start_flag_bit = 7;
   localparam int counter_overflow_flag_bit = 6;
   localparam int stop_flag_bit = 5;
   localparam int data_collision_flag_bit = 4;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] byte_reset = 8'h00;

   // bus operations issued by the core
   typedef enum logic [2:0] {
      op_idle,
      op_read,
      op_write,
      op_bit_set,
      op_bit_clear,
      op_bit_test
   } io_op_t;

endpackage : io_map_pkg

// >>> rtl/io_register_bank.sv
// i/o register bank with byte and single-bit access from the core
//
// Notes on behaviour
// - bit set/clear only at addresses 0x00..0x1f
// - bit test answers any bit, low range
// - status flags clear on writing one
// - bit ops touch only the addressed bit
// - nine-bit stack pointer, 0x3d low, 0x3e high
// - port value, direction, pins: six bits each
// - pin-change mask six bits at 0x15
// - timer0 control: modes a, b, waveform
// - general timer control field layout at 0x2c
// - pll control: low speed, clock en, lock
// - clock prescale: change enable plus select
// - serial control field layout at 0x0d
// - serial status: four flags, four-bit counter
// - comparator register layout at 0x08
// - converter input select layout at 0x07
// - converter control a layout at 0x06
// - conversion result as high and low bytes
// - converter control b layout at 0x03
`timescale 1ns/1ps
module io_register_bank
   import io_map_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   // core access port
   input wire io_map_pkg::io_op_t io_op,
   input wire logic [5:0] io_addr,
   input wire logic [2:0] io_bit,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_bit_value,
   // live inputs from the peripherals
   input wire logic [5:0] port_pins,
   input wire logic pll_lock_in,
   input wire logic comparator_level,
   input wire logic comparator_event,
   input wire logic converter_done,
   input wire logic [9:0] conversion_value,
   input wire logic [3:0] serial_events,
   input wire logic [3:0] serial_count,
   input wire logic serial_count_load,
   // register contents towards the peripherals
   output logic [7:0] processor_flags,
   output logic [8:0] stack_pointer,
   output logic [5:0] port_output_value,
   output logic [5:0] port_direction,
   output logic [5:0] pin_change_mask,
   output logic [7:0] timer0_control_a,
   output logic [7:0] general_timer_control,
   output logic [7:0] pll_control_status,
   output logic [7:0] clock_prescale,
   output logic [7:0] serial_iface_control,
   output logic [7:0] comparator_control_status,
   output logic [7:0] converter_input_select,
   output logic [7:0] converter_control_a,
   output logic [7:0] converter_control_b
);
   import io_map_pkg::*;

   // ****************************************
   // register state
   // ****************************************
   logic [7:0] flags_r;
   logic [7:0] sp_low_r;
   logic [7:0] sp_high_r;
   logic [7:0] port_out_r;
   logic [7:0] port_dir_r;
   logic [7:0] pin_mask_r;
   logic [7:0] pins_r;
   logic [7:0] t0_ctl_r;
   logic [7:0] gtc_r;
   logic [7:0] pll_r;
   logic [7:0] presc_r;
   logic [7:0] ser_ctl_r;
   logic [7:0] ser_stat_r;
   logic [7:0] comp_r;
   logic [7:0] mux_r;
   logic [7:0] adc_a_r;
   logic [7:0] adc_b_r;
   logic [7:0] scratch_r;
   logic [7:0] t0_cmp_a_r;
   logic [7:0] t0_cmp_b_r;
   logic [7:0] t1_cmp_b_r;
   logic [7:0] t1_cmp_c_r;
   logic [7:0] result_hi_r;
   logic [7:0] result_lo_r;
   logic [7:0] rdata_r;
   logic bit_value_r;

   // ****************************************
   // access decode
   // ****************************************
   // a bit op outside the low range is dropped whole
   wire logic low_range = (io_addr <= bit_access_top_addr);
   wire logic bit_op = ((io_op == op_bit_set) || (io_op == op_bit_clear)) && low_range;
   wire logic byte_wr = (io_op == op_write);
   wire logic wr_any = byte_wr || bit_op;
   wire logic [7:0] bit_sel = 8'h01 << io_bit;
   // byte write writes all bits; bit op only the selected one
   wire logic [7:0] wr_en = byte_wr ? 8'hff : (bit_op ? bit_sel : 8'h00);
   wire logic [7:0] bit_fill = (io_op == op_bit_set) ? 8'hff : 8'h00;
   wire logic [7:0] wr_val = byte_wr ? io_wdata : bit_fill;
   // ones written onto flag positions; a bit set on a flag clears it alone
   wire logic [7:0] w1c = wr_en & wr_val;

   // ****************************************
   // read mux
   // ****************************************
   logic [7:0] rd_mux;
   always_comb begin
      case (io_addr)
         processor_flags_addr: rd_mux = flags_r;
         stack_pointer_low_addr: rd_mux = sp_low_r;
         stack_pointer_high_addr: rd_mux = sp_high_r;
         port_output_value_addr: rd_mux = port_out_r;
         port_direction_addr: rd_mux = port_dir_r;
         port_pin_inputs_addr: rd_mux = pins_r;
         pin_change_mask_addr: rd_mux = pin_mask_r;
         timer0_control_a_addr: rd_mux = t0_ctl_r;
         timer0_compare_a_addr: rd_mux = t0_cmp_a_r;
         timer0_compare_b_addr: rd_mux = t0_cmp_b_r;
         timer1_compare_b_addr: rd_mux = t1_cmp_b_r;
         timer1_compare_c_addr: rd_mux = t1_cmp_c_r;
         general_timer_control_addr: rd_mux = gtc_r;
         pll_control_status_addr: rd_mux = pll_r;
         clock_prescale_addr: rd_mux = presc_r;
         serial_iface_control_addr: rd_mux = ser_ctl_r;
         serial_iface_status_addr: rd_mux = ser_stat_r;
         general_scratch_byte_1_addr: rd_mux = scratch_r;
         comparator_control_status_addr: rd_mux = comp_r;
         converter_input_select_addr: rd_mux = mux_r;
         converter_control_a_addr: rd_mux = adc_a_r;
         conversion_result_high_addr: rd_mux = result_hi_r;
         conversion_result_low_addr: rd_mux = result_lo_r;
         converter_control_b_addr: rd_mux = adc_b_r;
         default: rd_mux = byte_reset; // reserved addresses read zero
      endcase
   end

   // bit test reads one bit straight out, low range only
   wire logic bit_test = (io_op == op_bit_test) && low_range;

   // ****************************************
   // write helpers
   // ****************************************
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
      merge = ((old & ~wr_en) | (wr_val & wr_en)) & mask;
   endfunction : merge

   wire logic hit_flags = wr_any && (io_addr == processor_flags_addr);
   wire logic hit_spl = wr_any && (io_addr == stack_pointer_low_addr);
   wire logic hit_sph = wr_any && (io_addr == stack_pointer_high_addr);
   wire logic hit_pout = wr_any && (io_addr == port_output_value_addr);
   wire logic hit_pdir = wr_any && (io_addr == port_direction_addr);
   wire logic hit_pmsk = wr_any && (io_addr == pin_change_mask_addr);
   wire logic hit_t0c = wr_any && (io_addr == timer0_control_a_addr);
   wire logic hit_t0a = wr_any && (io_addr == timer0_compare_a_addr);
   wire logic hit_t0b = wr_any && (io_addr == timer0_compare_b_addr);
   wire logic hit_t1b = wr_any && (io_addr == timer1_compare_b_addr);
   wire logic hit_t1c = wr_any && (io_addr == timer1_compare_c_addr);
   wire logic hit_gtc = wr_any && (io_addr == general_timer_control_addr);
   wire logic hit_pll = wr_any && (io_addr == pll_control_status_addr);
   wire logic hit_pre = wr_any && (io_addr == clock_prescale_addr);
   wire logic hit_sctl = wr_any && (io_addr == serial_iface_control_addr);
   wire logic hit_sst = wr_any && (io_addr == serial_iface_status_addr);
   wire logic hit_scr = wr_any && (io_addr == general_scratch_byte_1_addr);
   wire logic hit_cmp = wr_any && (io_addr == comparator_control_status_addr);
   wire logic hit_mux = wr_any && (io_addr == converter_input_select_addr);
   wire logic hit_ada = wr_any && (io_addr == converter_control_a_addr);
   wire logic hit_adb = wr_any && (io_addr == converter_control_b_addr);

   // ****************************************
   // status flags: hardware set wins over software clear
   // ****************************************
   wire logic [7:0] comp_clr = hit_cmp ? w1c : 8'h00;
   wire logic comp_flag_nxt = comparator_event ||
                              (comp_r[comparator_irq_flag_bit] &&
                               !comp_clr[comparator_irq_flag_bit]);
   // written values spelled out: a continuous assign would not wake on the
   // function's own reads of wr_en and wr_val
   wire logic [7:0] comp_wr = (comp_r & ~wr_en) | (wr_val & wr_en);
   wire logic [7:0] comp_nxt = ((hit_cmp ? comp_wr : comp_r) & comparator_write_mask) |
                               ({7'h00, comparator_level} << comparator_output_bit) |
                               ({7'h00, comp_flag_nxt} << comparator_irq_flag_bit);

   wire logic [7:0] ada_clr = hit_ada ? w1c : 8'h00;
   wire logic ada_flag_nxt = converter_done ||
                             (adc_a_r[converter_irq_flag_bit] &&
                              !ada_clr[converter_irq_flag_bit]);
   wire logic [7:0] ada_wr = (adc_a_r & ~wr_en) | (wr_val & wr_en);
   wire logic [7:0] ada_nxt = ((hit_ada ? ada_wr : adc_a_r) & converter_a_write_mask) |
                              ({7'h00, ada_flag_nxt} << converter_irq_flag_bit);

   // serial status: upper nibble write-one-to-clear, counter written or loaded
   wire logic [3:0] ser_clr = hit_sst ? w1c[7:4] : 4'h0;
   wire logic [3:0] ser_flags_nxt = serial_events | (ser_stat_r[7:4] & ~ser_clr);
   wire logic [7:0] ser_wr = ((ser_stat_r & ~wr_en) | (wr_val & wr_en)) & serial_status_cnt_mask;
   wire logic [3:0] ser_cnt_wr = ser_wr[3:0];
   wire logic [3:0] ser_cnt_nxt = serial_count_load ? serial_count :
                                  (hit_sst ? ser_cnt_wr : ser_stat_r[3:0]);

   // pll: lock bit mirrors hardware, not writable
   wire logic [7:0] pll_wr = (pll_r & ~wr_en) | (wr_val & wr_en);
   wire logic [7:0] pll_nxt = ((hit_pll ? pll_wr : pll_r) & pll_write_mask) |
                              ({7'h00, pll_lock_in} << pll_locked_bit);

   // left-adjust chooses how the ten result bits sit in the two bytes
   wire logic [15:0] result_word = mux_r[5] ? {conversion_value, 6'h00}
                                            : {6'h00, conversion_value};

   // ****************************************
   // register update
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_r <= byte_reset;
         sp_low_r <= byte_reset;
         sp_high_r <= byte_reset;
         port_out_r <= byte_reset;
         port_dir_r <= byte_reset;
         pin_mask_r <= byte_reset;
         pins_r <= byte_reset;
         t0_ctl_r <= byte_reset;
         t0_cmp_a_r <= byte_reset;
         t0_cmp_b_r <= byte_reset;
         t1_cmp_b_r <= byte_reset;
         t1_cmp_c_r <= byte_reset;
         gtc_r <= byte_reset;
         pll_r <= byte_reset;
         presc_r <= byte_reset;
         ser_ctl_r <= byte_reset;
         ser_stat_r <= byte_reset;
         scratch_r <= byte_reset;
         comp_r <= byte_reset;
         mux_r <= byte_reset;
         adc_a_r <= byte_reset;
         adc_b_r <= byte_reset;
         result_hi_r <= byte_reset;
         result_lo_r <= byte_reset;
         rdata_r <= byte_reset;
         bit_value_r <= 1'b0;
      end else begin
         if (hit_flags) flags_r <= merge(flags_r, 8'hff);
         if (hit_spl) sp_low_r <= merge(sp_low_r, 8'hff);
         if (hit_sph) sp_high_r <= merge(sp_high_r, stack_high_mask);
         if (hit_pout) port_out_r <= merge(port_out_r, port_bits_mask);
         if (hit_pdir) port_dir_r <= merge(port_dir_r, port_bits_mask);
         if (hit_pmsk) pin_mask_r <= merge(pin_mask_r, port_bits_mask);
         pins_r <= {2'b00, port_pins};
         if (hit_t0c) t0_ctl_r <= merge(t0_ctl_r, timer0_control_mask);
         if (hit_t0a) t0_cmp_a_r <= merge(t0_cmp_a_r, 8'hff);
         if (hit_t0b) t0_cmp_b_r <= merge(t0_cmp_b_r, 8'hff);
         if (hit_t1b) t1_cmp_b_r <= merge(t1_cmp_b_r, 8'hff);
         if (hit_t1c) t1_cmp_c_r <= merge(t1_cmp_c_r, 8'hff);
         if (hit_gtc) gtc_r <= merge(gtc_r, 8'hff);
         pll_r <= pll_nxt;
         if (hit_pre) presc_r <= merge(presc_r, prescale_write_mask);
         if (hit_sctl) ser_ctl_r <= merge(ser_ctl_r, 8'hff);
         ser_stat_r <= {ser_flags_nxt, ser_cnt_nxt};
         if (hit_scr) scratch_r <= merge(scratch_r, 8'hff);
         comp_r <= comp_nxt;
         if (hit_mux) mux_r <= merge(mux_r, 8'hff);
         adc_a_r <= ada_nxt;
         if (hit_adb) adc_b_r <= merge(adc_b_r, converter_b_mask);
         if (converter_done) begin
            result_hi_r <= result_word[15:8];
            result_lo_r <= result_word[7:0];
         end
         if (io_op == op_read) rdata_r <= rd_mux;
         if (bit_test) bit_value_r <= rd_mux[io_bit];
      end
   end

   // ****************************************
   // outputs straight from flip-flops
   // ****************************************
   assign io_rdata = rdata_r;
   assign io_bit_value = bit_value_r;
   assign processor_flags = flags_r;
   assign stack_pointer = {sp_high_r[0], sp_low_r};
   assign port_output_value = port_out_r[5:0];
   assign port_direction = port_dir_r[5:0];
   assign pin_change_mask = pin_mask_r[5:0];
   assign timer0_control_a = t0_ctl_r;
   assign general_timer_control = gtc_r;
   assign pll_control_status = pll_r;
   assign clock_prescale = presc_r;
   assign serial_iface_control = ser_ctl_r;
   assign comparator_control_status = comp_r;
   assign converter_input_select = mux_r;
   assign converter_control_a = adc_a_r;
   assign converter_control_b = adc_b_r;

endmodule : io_register_bank

// >>> verif/io_bank_assertions.sv
// concurrent checks on the access port of the i/o register bank
`timescale 1ns/1ps
module io_bank_assertions
   import io_map_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire io_map_pkg::io_op_t io_op,
   input wire logic [5:0] io_addr,
   input wire logic [2:0] io_bit,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_bit_value,
   input wire logic pll_lock_in,
   input wire logic comparator_event,
   input wire logic [7:0] processor_flags,
   input wire logic [8:0] stack_pointer,
   input wire logic [5:0] port_output_value,
   input wire logic [5:0] port_direction,
   input wire logic [7:0] comparator_control_status,
   input wire logic [7:0] pll_control_status
);
   // one clock domain, so clocking and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // ****************************************
   // single-bit operations
   // ****************************************
   sequence s_port_set;
      io_op == op_bit_set && io_addr == port_output_value_addr;
   endsequence
   sequence s_port_clear;
      io_op == op_bit_clear && io_addr == port_output_value_addr;
   endsequence
   property p_set_one;
      s_port_set |=> port_output_value == ($past(port_output_value) | (6'h01 << $past(io_bit)));
   endproperty
   a_set_one: assert property (p_set_one) else $error("bit set touched other bits");
   property p_clear_one;
      s_port_clear |=> port_output_value ==
         ($past(port_output_value) & ~(6'h01 << $past(io_bit)));
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("bit clear went wrong");
   property p_high_ignored;
      io_op inside {op_bit_set, op_bit_clear} && io_addr > bit_access_top_addr
         |=> $stable(processor_flags) && $stable(stack_pointer);
   endproperty
   a_high_ignored: assert property (p_high_ignored) else $error("bit op above range acted");
   property p_test_low;
      io_op == op_bit_test && io_addr == port_direction_addr
         |=> io_bit_value == |({2'b00, port_direction} & (8'h01 << $past(io_bit)));
   endproperty
   a_test_low: assert property (p_test_low) else $error("bit test gave wrong value");
   property p_test_high;
      io_op == op_bit_test && io_addr > bit_access_top_addr |=> $stable(io_bit_value);
   endproperty
   a_test_high: assert property (p_test_high) else $error("bit test above range acted");

   // ****************************************
   // byte access, flags and live bits
   // ****************************************
   property p_read_flags;
      io_op == op_read && io_addr == processor_flags_addr |=> io_rdata == processor_flags;
   endproperty
   a_read_flags: assert property (p_read_flags) else $error("flags read mismatch");
   property p_sp_high;
      io_op == op_write && io_addr == stack_pointer_high_addr
         |=> stack_pointer[8] == $past(io_wdata[0]) && $stable(stack_pointer[7:0]);
   endproperty
   a_sp_high: assert property (p_sp_high) else $error("stack pointer high write wrong");
   property p_w1c_clear;
      io_op == op_write && io_addr == comparator_control_status_addr && io_wdata[4]
         && !comparator_event |=> !comparator_control_status[4];
   endproperty
   a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared by one");
   property p_w1c_keep;
      io_op == op_write && io_addr == comparator_control_status_addr && !io_wdata[4]
         && comparator_control_status[4] |=> comparator_control_status[4];
   endproperty
   a_w1c_keep: assert property (p_w1c_keep) else $error("flag lost on writing zero");
   property p_lock;
      $changed(pll_lock_in) |=> pll_control_status[0] == $past(pll_lock_in);
   endproperty
   a_lock: assert property (p_lock) else $error("lock bit does not follow input");
endmodule : io_bank_assertions

bind io_register_bank io_bank_assertions io_bank_assertions_inst (
   .clk, .rstn, .io_op, .io_addr, .io_bit, .io_wdata, .io_rdata, .io_bit_value,
   .pll_lock_in, .comparator_event, .processor_flags, .stack_pointer, .port_output_value,
   .port_direction, .comparator_control_status, .pll_control_status
);

// >>> verif/io_register_bank_test.sv
// self-checking bench for the i/o register bank
`timescale 1ns/1ps
module io_register_bank_test;
   import io_map_pkg::*;
   typedef struct {logic is_bit; logic [7:0] val;} note_t;
   logic clk, rstn, io_bit_value, pll_lock_in, comparator_level, comparator_event;
   logic converter_done, serial_count_load, watch, last_bit;
   io_op_t io_op;
   logic [5:0] io_addr, port_pins, pins;
   logic [2:0] io_bit;
   logic [7:0] io_wdata, io_rdata, d, e;
   logic [9:0] conversion_value, cv;
   logic [3:0] serial_events, serial_count, cnt;
   note_t notes[$];
   note_t n;
   int n_errors = 0;
   int n_tests = 0;
   // writable registers, reserved and read-only places, with the bits that hold data
   logic [5:0] ra [0:22] = '{6'h03, 6'h04, 6'h06, 6'h07, 6'h08, 6'h0d, 6'h12, 6'h15, 6'h16,
      6'h17, 6'h18, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h3c, 6'h3d,
      6'h3e, 6'h3f};
   logic [7:0] rm [0:22] = '{8'he7, 8'h00, 8'hef, 8'hff, 8'hcb, 8'hff, 8'hff, 8'h3f, 8'h00,
      8'h3f, 8'h3f, 8'h8f, 8'h86, 8'hff, 8'hff, 8'hf3, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
      8'h01, 8'hff};
   // bits that software may write: everything but the reserved positions
   logic [7:0] wm [0:22] = '{8'he7, 8'hff, 8'hff, 8'hff, 8'hfb, 8'hff, 8'hff, 8'h3f, 8'h3f,
      8'h3f, 8'h3f, 8'h8f, 8'h87, 8'hff, 8'hff, 8'hf3, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
      8'h01, 8'hff};

   io_register_bank io_register_bank_inst (.clk, .rstn, .io_op, .io_addr, .io_bit, .io_wdata,
      .io_rdata, .io_bit_value, .port_pins, .pll_lock_in, .comparator_level, .comparator_event,
      .converter_done, .conversion_value, .serial_events, .serial_count, .serial_count_load,
      .processor_flags(), .stack_pointer(), .port_output_value(), .port_direction(),
      .pin_change_mask(), .timer0_control_a(), .general_timer_control(),
      .pll_control_status(), .clock_prescale(), .serial_iface_control(),
      .comparator_control_status(), .converter_input_select(), .converter_control_a(),
      .converter_control_b());

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************
   // driver, monitor and comparison
   // ****************************************
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   // an op is held until the next call replaces it, so waits go through pulse first
   task automatic op(io_op_t k, logic [5:0] a, logic [2:0] b, logic [7:0] w);
      @(posedge clk);
      io_op <= k;
      io_addr <= a;
      io_bit <= b;
      io_wdata <= w;
   endtask : op
   task automatic rd(logic [5:0] a, logic [7:0] x);
      notes.push_back('{1'b0, x});
      op(op_read, a, 3'h0, 8'h00);
   endtask : rd
   // above the bit range the last tested value must simply hold
   task automatic tst(logic [5:0] a, logic [2:0] b, logic x);
      if (a <= bit_access_top_addr) last_bit = x;
      notes.push_back('{1'b1, {7'h00, last_bit}});
      op(op_bit_test, a, b, 8'h00);
   endtask : tst
   task automatic pulse(logic ce, logic cd, logic [3:0] se);
      @(posedge clk);
      io_op <= op_idle;
      comparator_event <= ce;
      converter_done <= cd;
      serial_events <= se;
      serial_count_load <= 1'b1;
      serial_count <= cnt;
      conversion_value <= cv;
      port_pins <= pins;
      pll_lock_in <= 1'b1;
      comparator_level <= 1'b1;
      @(posedge clk);
      comparator_event <= 1'b0;
      converter_done <= 1'b0;
      serial_events <= 4'h0;
      serial_count_load <= 1'b0;
   endtask : pulse
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up

   // answers appear the cycle after the op is taken, so compare on the falling edge
   always @(posedge clk) watch <= rstn && (io_op == op_read || io_op == op_bit_test);
   always @(negedge clk) begin
      if (watch) begin
         n = notes.pop_front();
         check(n.is_bit ? {7'h00, io_bit_value} : io_rdata, n.val);
      end
   end

   // a hang costs far more than the whole sequence needs
   initial begin
      #20000;
      n_errors++;
      wrap_up();
   end

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      void'($urandom(99245));
      {rstn, pll_lock_in, comparator_level, comparator_event, converter_done} = 5'h00;
      {serial_count_load, last_bit} = 2'h0;
      io_op = op_idle;
      {io_addr, io_bit, io_wdata, port_pins, conversion_value} = 33'h0;
      {serial_events, serial_count} = 8'h00;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      // reset values, then writes with random data through every register but 0x05 and 0x0e
      foreach (ra[i]) rd(ra[i], 8'h00);
      foreach (ra[i]) begin
         d = 8'($urandom) & wm[i];
         if (ra[i] != 6'h3c) op(op_write, ra[i], 3'h0, d);
         rd(ra[i], d & rm[i]);
         e = d & rm[i];
         tst(ra[i], 3'(i), e[i % 8]);
      end
      // set single port bits with zero data, then clear some with a full byte on the data lines
      op(op_write, 6'h18, 3'h0, 8'h00);
      e = 8'h00;
      // reserved bit 6 is only ever cleared and bit 7 never touched; neither is set
      for (int b = 0; b < 6; b++) begin
         e = e | (8'h01 << b) & 8'h3f;
         op(op_bit_set, 6'h18, 3'(b), 8'h00);
         rd(6'h18, e);
      end
      for (int b = 0; b < 8; b += 3) begin
         e = e & ~(8'h01 << b);
         op(op_bit_clear, 6'h18, 3'(b), 8'hff);
         rd(6'h18, e);
      end
      for (int b = 0; b < 8; b++) tst(6'h18, 3'(b), e[b]);
      // above the bit range nothing moves
      op(op_write, 6'h3f, 3'h0, 8'h5a);
      for (int b = 0; b < 8; b++) op(b[0] ? op_bit_set : op_bit_clear, 6'h3f, 3'(b), 8'h00);
      rd(6'h3f, 8'h5a);
      tst(6'h3f, 3'h1, 1'b0);
      // event flags, clearing by writing one, live inputs, conversion result
      cv = 10'($urandom);
      cnt = 4'($urandom);
      pins = 6'($urandom);
      op(op_write, 6'h08, 3'h0, 8'h08);
      op(op_write, 6'h06, 3'h0, 8'h80);
      op(op_write, 6'h07, 3'h0, 8'h00);
      op(op_write, 6'h27, 3'h0, 8'h84);
      pulse(1'b1, 1'b1, 4'hf);
      rd(6'h08, 8'h38);
      op(op_write, 6'h08, 3'h0, 8'h08);
      op(op_bit_clear, 6'h08, 3'h4, 8'h00);
      rd(6'h08, 8'h38);
      op(op_bit_set, 6'h08, 3'h4, 8'h00);
      rd(6'h08, 8'h28);
      rd(6'h0e, {4'hf, cnt});
      op(op_bit_set, 6'h0e, 3'h6, 8'h00);
      op(op_bit_set, 6'h0e, 3'h4, 8'h00);
      rd(6'h0e, {4'ha, cnt});
      rd(6'h05, {6'h00, cv[9:8]});
      rd(6'h04, cv[7:0]);
      rd(6'h06, 8'h90);
      op(op_write, 6'h06, 3'h0, 8'h90);
      rd(6'h06, 8'h80);
      rd(6'h16, {2'b00, pins});
      rd(6'h27, 8'h85);
      op(op_write, 6'h07, 3'h0, 8'h20);
      pulse(1'b0, 1'b1, 4'h0);
      rd(6'h05, cv[9:2]);
      rd(6'h04, {cv[1:0], 6'h00});
      // second reset in mid-run
      pulse(1'b0, 1'b0, 4'h0);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(6'h18, 8'h00);
      rd(6'h3f, 8'h00);
      rd(6'h08, 8'h20);
      pulse(1'b0, 1'b0, 4'h0);
      repeat (2) @(posedge clk);
      wrap_up();
   end
endmodule : io_register_bank_test
